// [inc/emb_pkg.sv]
// Function
// RQ1: Clock output runs at one third of oscillator, high one third of period.
// RQ2: External source holds reset low at least ten oscillator cycles.
// RQ3: Reset release resynchronises clock output, then ten state time reset sequence.
// RQ4: Config bit 1 set: width input picks 16-bit or 8-bit per cycle.
// RQ5: Config bit 1 clear: every external cycle is 8-bit.
// RQ6: Rising edge on NMI input vectors execution to address 0000H.
// RQ7: Fetch indicator high during external instruction fetch, valid whole cycle.
// RQ8: ROM select high maps 2000H-3FFFH on chip, low maps it external.
// RQ9: ROM select at programming voltage enters programming mode.
// RQ10: Config picks latch enable or address valid strobe form.
// RQ11: Address valid form returns strobe high at end of cycle.
// RQ12: Address strobe pulses only for external accesses.
// RQ13: Read strobe low only during external reads.
// RQ14: Plain write strobe low for every external write.
// RQ15: Low byte write strobe low only for writes including even byte.
// RQ16: High byte enable low for writes using the upper data byte.
// RQ17: High byte write strobe low for writes of an odd byte.
// RQ18: High strobe and write strobe active only during external writes.
// RQ19: Memory may hold ready low to stretch the cycle.
// RQ20: External latch captures address on the strobe edge.
package emb_pkg;
   localparam int CLK_DIV = 3;
   localparam int CLK_HIGH = 1;
   localparam int RST_SEQ_STATES = 10;
   localparam logic [15:0] NMI_VECTOR = 16'h0000;
   localparam logic [15:0] ROM_LO = 16'h2000;
   localparam logic [15:0] ROM_HI = 16'h3fff;
   localparam int CFG_WIDTH_BIT = 1;

   typedef struct packed {
      logic rd;
      logic wr;
      logic fetch;
      logic word;
      logic [15:0] addr;
      logic [15:0] wdata;
   } emb_req_t;

   typedef struct packed {
      logic ale_n;
      logic rd_n;
      logic wr_n;
      logic hi_n;
      logic fetch;
      logic ad_oe;
      logic [15:0] ad;
   } emb_pins_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_STRB = 3'b010,
      ST_WAIT = 3'b011,
      ST_DONE = 3'b100
   } emb_state_t;
endpackage

// [core/emb_clkgen.sv]
`timescale 1ns/10ps
// Divide-by-three clock output with reset resynchronisation and state ticks
module emb_clkgen
   import emb_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   output logic divided_clock_output_out,
   output logic tick_out
);
   logic [1:0] phase_q;
   logic [1:0] phase_d;

   // Phase count wraps every three oscillator cycles
   assign phase_d = (phase_q == 2'(CLK_DIV - 1)) ? 2'h0 : phase_q + 2'h1;

   // Reset holds phase at zero so release restarts the clock output [RQ3]
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         phase_q <= 2'h0;
      else
         phase_q <= phase_d;
   end

   assign divided_clock_output_out = (phase_q < 2'(CLK_HIGH)); // [RQ1]
   assign tick_out = (phase_q == 2'(CLK_DIV - 1));

   a_clk_third: assert property (@(posedge clk_in) disable iff (rst_in)
      divided_clock_output_out |=> !divided_clock_output_out ##1 !divided_clock_output_out ##1 divided_clock_output_out) else $error("clock output not one third"); // [RQ1]
endmodule

// [core/emb_strobes.sv]
`timescale 1ns/10ps
// Strobe and lane decode for one bus cycle phase
module emb_strobes
   import emb_pkg::*;
(
   input wire logic strb_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic word_in,
   input wire logic a0_in,
   input wire logic wrl_mode_in,
   input wire logic wrh_mode_in,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic hi_n_out
);
   logic hi_used;
   logic lo_used;

   // Lane use from width and address parity
   assign lo_used = word_in || !a0_in;
   assign hi_used = word_in || a0_in;
   assign rd_n_out = !(strb_in && rd_in); // [RQ13]
   // Plain strobe for every write, low byte form only with even byte [RQ14] [RQ15] [RQ18]
   assign wr_n_out = !(strb_in && wr_in && (!wrl_mode_in || lo_used));
   // High enable or odd byte strobe, both writes only [RQ16] [RQ17] [RQ18]
   assign hi_n_out = !(strb_in && wr_in && (wrh_mode_in ? hi_used : hi_used));
endmodule

// [core/emb_bus.sv]
`timescale 1ns/10ps
// External memory bus sequencer: reset sequence, ROM steering, width, strobes
module emb_bus
   import emb_pkg::*;
#(
   parameter int SEQ_STATES = RST_SEQ_STATES
)
(
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic REQ_VALID_IN,
   input wire emb_req_t REQ_IN,
   output logic REQ_READY_OUT,
   output logic [15:0] RDATA_OUT,
   output logic RDATA_VALID_OUT,
   output logic ONCHIP_SEL_OUT,
   input wire logic [1:0] CFG_IN,
   input wire logic ADV_MODE_IN,
   input wire logic WRL_MODE_IN,
   input wire logic WRH_MODE_IN,
   input wire logic BUS_WIDTH_SELECT_IN,
   input wire logic ONCHIP_ROM_SELECT_IN,
   input wire logic PROG_LEVEL_IN,
   input wire logic NMI_IN,
   input wire logic READY_IN,
   input wire logic [15:0] AD_IN,
   output logic [15:0] AD_OUT,
   output logic AD_OE_OUT,
   output logic DIVIDED_CLOCK_OUTPUT_OUT,
   output logic ADDR_STROBE_OUT,
   output logic RD_N_OUT,
   output logic LOW_BYTE_STORE_N_OUT,
   output logic HIGH_BYTE_STORE_N_OUT,
   output logic FETCH_INDICATOR_OUT,
   output logic NMI_VECTOR_OUT,
   output logic [15:0] NMI_ADDR_OUT,
   output logic PROG_MODE_OUT,
   output logic RUN_OUT
);
   emb_state_t state_q;
   emb_state_t state_d;
   emb_req_t req_q;
   logic [3:0] seq_q;
   logic run_q;
   logic nmi_q;
   logic word_q;
   logic prog_q;
   logic vec_q;
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic tick;
   logic divided_clock_output;
   logic strb;
   logic in_rom;
   logic take;
   logic rd_n;
   logic wr_n;
   logic hi_n;

   emb_clkgen u_clk (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .divided_clock_output_out(divided_clock_output),
      .tick_out(tick)
   );

   // Ten state time sequence after reset release [RQ3]
   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         seq_q <= 4'h0;
      else if (tick && !run_q)
         seq_q <= seq_q + 4'h1;
   end

   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         run_q <= 1'b0;
      else if (tick && seq_q == 4'(SEQ_STATES - 1))
         run_q <= 1'b1; // [RQ3]
   end

   // ROM window steering [RQ8]
   assign in_rom = ONCHIP_ROM_SELECT_IN && (REQ_IN.addr >= ROM_LO) && (REQ_IN.addr <= ROM_HI);
   assign ONCHIP_SEL_OUT = REQ_VALID_IN && run_q && in_rom;
   assign take = REQ_VALID_IN && run_q && !prog_q && !in_rom && (state_q == ST_IDLE) && tick;
   assign REQ_READY_OUT = (REQ_VALID_IN && run_q && in_rom) || take;

   // Bus cycle sequence, one state per state time
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: if (take) state_d = ST_ADDR;
         ST_ADDR: if (tick) state_d = ST_STRB;
         ST_STRB: if (tick) state_d = READY_IN ? ST_DONE : ST_WAIT;
         ST_WAIT: if (tick && READY_IN) state_d = ST_DONE; // [RQ19]
         ST_DONE: if (tick) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // Request capture and per cycle width [RQ4] [RQ5]
   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         req_q <= '0;
         word_q <= 1'b0;
      end
      else if (take)
      begin
         req_q <= REQ_IN;
         word_q <= REQ_IN.word && CFG_IN[CFG_WIDTH_BIT] && BUS_WIDTH_SELECT_IN;
      end
   end

   // Read data taken while the read strobe still stands; the bus floats to the pull-ups afterwards
   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= (state_q == ST_DONE) && tick && req_q.rd;
         if (strb && tick && READY_IN && req_q.rd) // [RQ19]
            rdata_q <= word_q ? AD_IN : {8'h00, AD_IN[7:0]};
      end
   end

   // NMI edge, programming level
   always_ff @(posedge MCLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         nmi_q <= 1'b0;
         vec_q <= 1'b0;
         prog_q <= 1'b0;
      end
      else
      begin
         nmi_q <= NMI_IN;
         vec_q <= NMI_IN && !nmi_q && run_q; // [RQ6]
         prog_q <= PROG_LEVEL_IN; // [RQ9]
      end
   end

   assign strb = (state_q == ST_STRB) || (state_q == ST_WAIT);

   emb_strobes u_strb (
      .strb_in(strb),
      .rd_in(req_q.rd),
      .wr_in(req_q.wr),
      .word_in(word_q),
      .a0_in(req_q.addr[0]),
      .wrl_mode_in(WRL_MODE_IN),
      .wrh_mode_in(WRH_MODE_IN),
      .rd_n_out(rd_n),
      .wr_n_out(wr_n),
      .hi_n_out(hi_n)
   );

   // Pin drive
   assign DIVIDED_CLOCK_OUTPUT_OUT = divided_clock_output;
   // Latch enable pulses in address phase; address valid low for whole cycle [RQ10] [RQ11] [RQ12]
   assign ADDR_STROBE_OUT = ADV_MODE_IN ? (state_q == ST_IDLE) : (state_q == ST_ADDR);
   assign RD_N_OUT = rd_n;
   assign LOW_BYTE_STORE_N_OUT = wr_n;
   assign HIGH_BYTE_STORE_N_OUT = hi_n;
   assign FETCH_INDICATOR_OUT = (state_q != ST_IDLE) && req_q.rd && req_q.fetch; // [RQ7]
   assign AD_OE_OUT = (state_q == ST_ADDR) || (strb && req_q.wr);
   assign AD_OUT = (state_q == ST_ADDR) ? req_q.addr : req_q.wdata;
   assign RDATA_OUT = rdata_q;
   assign RDATA_VALID_OUT = rvalid_q;
   assign NMI_VECTOR_OUT = vec_q;
   assign NMI_ADDR_OUT = NMI_VECTOR; // [RQ6]
   assign PROG_MODE_OUT = prog_q;
   assign RUN_OUT = run_q;

   a_strobe_internal: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      (state_q == ST_IDLE) |-> RD_N_OUT && LOW_BYTE_STORE_N_OUT && HIGH_BYTE_STORE_N_OUT) else $error("strobe idle"); // [RQ18]
   a_read_only: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      !RD_N_OUT |-> req_q.rd && !req_q.wr) else $error("read strobe outside read"); // [RQ13]
   a_width_narrow: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      take && !CFG_IN[CFG_WIDTH_BIT] |=> !word_q) else $error("wide cycle with bit clear"); // [RQ5]
   a_width_pin: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      take && REQ_IN.word && CFG_IN[CFG_WIDTH_BIT] |=> word_q == $past(BUS_WIDTH_SELECT_IN)) else $error("width"); // [RQ4]
   a_rom_window: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      take |-> !(ONCHIP_ROM_SELECT_IN && REQ_IN.addr >= ROM_LO && REQ_IN.addr <= ROM_HI)) else $error("rom"); // [RQ8]
   a_nmi_edge: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      run_q && $rose(NMI_IN) |=> NMI_VECTOR_OUT) else $error("nmi missed"); // [RQ6]
   a_adv_end: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      ADV_MODE_IN && state_q == ST_DONE && tick |=> ADDR_STROBE_OUT) else $error("adv not high"); // [RQ11]
   a_fetch_hold: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      take && REQ_IN.rd && REQ_IN.fetch |=> FETCH_INDICATOR_OUT [*3]) else $error("fetch dropped"); // [RQ7]
   a_lowbyte_even: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
      WRL_MODE_IN && !LOW_BYTE_STORE_N_OUT |-> word_q || !req_q.addr[0]) else $error("odd low store"); // [RQ15]
endmodule

// [dv/emb_ext_mem.sv]
`timescale 1ns/10ps
// External memory behind an address latch, with pull-ups and ready stretch
module emb_ext_mem
(
   input wire logic clk_in,
   input wire logic adv_mode_in,
   input wire logic strobe_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   input wire logic hi_n_in,
   input wire logic [15:0] ad_in,
   input wire logic [1:0] waits_in,
   output logic [15:0] ad_out,
   output logic ready_out
);
   logic [15:0] mem [256];
   logic [7:0] addr_q;
   logic strb_q;
   logic [1:0] cnt_q = 2'h0;
   wire idle = rd_n_in & wr_n_in & hi_n_in;
   // Address latch, word store and wait counter
   always @(posedge clk_in)
   begin
      strb_q <= strobe_in;
      if (adv_mode_in ? strb_q & !strobe_in : strobe_in)
         addr_q <= ad_in[8:1];
      if (!(wr_n_in & hi_n_in))
         mem[addr_q] <= ad_in;
      cnt_q <= idle ? 2'h0 : cnt_q + 2'(cnt_q != waits_in);
   end
   // Ready held low for the set number of clocks of each strobe
   assign ready_out = idle | cnt_q == waits_in;
   // Pull-ups own the bus unless the memory reads out
   assign ad_out = rd_n_in ? 16'hffff : mem[addr_q];
endmodule

// [dv/test_emb_bus.sv]
`timescale 1ns/10ps
// Reset, access table through the sequencer, wait stretch, clock, NMI, then reset and programming
module test_emb_bus
   import emb_pkg::*;
;
   typedef struct packed {
      logic [5:0] mode;
      emb_req_t req;
      logic [4:0] exp;
   } emb_row_t;
   logic MCLK_IN = 0, RST_IN = 1, REQ_VALID_IN = 0, ADV_MODE_IN = 0, WRL_MODE_IN = 0, WRH_MODE_IN = 0;
   logic BUS_WIDTH_SELECT_IN = 0, ONCHIP_ROM_SELECT_IN = 0, PROG_LEVEL_IN = 0, NMI_IN = 0, READY_IN;
   logic REQ_READY_OUT, RDATA_VALID_OUT, ONCHIP_SEL_OUT, AD_OE_OUT, DIVIDED_CLOCK_OUTPUT_OUT, ADDR_STROBE_OUT;
   logic RD_N_OUT, LOW_BYTE_STORE_N_OUT, HIGH_BYTE_STORE_N_OUT, FETCH_INDICATOR_OUT, NMI_VECTOR_OUT;
   logic PROG_MODE_OUT, RUN_OUT;
   logic [1:0] CFG_IN = 0, waits = 0;
   logic [15:0] AD_IN, AD_OUT, RDATA_OUT, NMI_ADDR_OUT, mem_ad;
   emb_req_t REQ_IN = '0;
   int errors = 0, checks = 0, lat, n;
   // Mode: adv, low store, high store, width enable, width pin, ROM select
   // Seen: onchip, read, write, high lane, fetch
   emb_row_t rows [13] = '{
      {6'h00, 4'h4, 16'h0102, 16'h0000, 5'h04}, {6'h18, 4'h4, 16'h0103, 16'h0000, 5'h02},
      {6'h00, 4'h4, 16'h0103, 16'h0000, 5'h06}, {6'h16, 4'h5, 16'h0100, 16'h1234, 5'h06},
      {6'h26, 4'hb, 16'h0100, 16'h1234, 5'h09}, {6'h02, 4'h5, 16'h0104, 16'h0000, 5'h04},
      {6'h01, 4'h8, 16'h2000, 16'h0000, 5'h10}, {6'h01, 4'h8, 16'h3fff, 16'h0000, 5'h10},
      {6'h01, 4'h8, 16'h4000, 16'h0000, 5'h08}, {6'h00, 4'h8, 16'h2000, 16'h0000, 5'h08},
      {6'h01, 4'h4, 16'h1ffe, 16'h0000, 5'h04}, {6'h04, 4'h5, 16'h0106, 16'h0000, 5'h04},
      {6'h00, 4'h9, 16'h0100, 16'h0034, 5'h08}};

   emb_bus #(.SEQ_STATES(2)) i_emb_bus (.MCLK_IN, .RST_IN, .REQ_VALID_IN, .REQ_IN, .REQ_READY_OUT,
      .RDATA_OUT, .RDATA_VALID_OUT, .ONCHIP_SEL_OUT, .CFG_IN, .ADV_MODE_IN, .WRL_MODE_IN, .WRH_MODE_IN,
      .BUS_WIDTH_SELECT_IN, .ONCHIP_ROM_SELECT_IN, .PROG_LEVEL_IN, .NMI_IN, .READY_IN, .AD_IN, .AD_OUT,
      .AD_OE_OUT, .DIVIDED_CLOCK_OUTPUT_OUT, .ADDR_STROBE_OUT, .RD_N_OUT, .LOW_BYTE_STORE_N_OUT,
      .HIGH_BYTE_STORE_N_OUT, .FETCH_INDICATOR_OUT, .NMI_VECTOR_OUT, .NMI_ADDR_OUT, .PROG_MODE_OUT, .RUN_OUT);
   emb_ext_mem i_emb_ext_mem (.clk_in(MCLK_IN), .adv_mode_in(ADV_MODE_IN), .strobe_in(ADDR_STROBE_OUT),
      .rd_n_in(RD_N_OUT), .wr_n_in(LOW_BYTE_STORE_N_OUT), .hi_n_in(HIGH_BYTE_STORE_N_OUT), .ad_in(AD_IN),
      .waits_in(waits), .ad_out(mem_ad), .ready_out(READY_IN));
   // Bus level: sequencer while enabled, else memory or pull-ups
   assign AD_IN = AD_OE_OUT ? AD_OUT : mem_ad;

   initial forever #50 MCLK_IN = ~MCLK_IN;

   task automatic chk(input string what, input logic [15:0] exp, got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize;
      if (errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Reset held 12 clocks, then the shortened sequence
   task automatic reset_seq;
      RST_IN = 1;
      repeat (12) @(negedge MCLK_IN); // At least ten oscillator cycles
      chk("reset pins", 16'hf, {RD_N_OUT, LOW_BYTE_STORE_N_OUT, HIGH_BYTE_STORE_N_OUT, RUN_OUT ^ 1'b1});
      RST_IN = 0;
      repeat (5) @(negedge MCLK_IN);
      chk("run early", 0, RUN_OUT);
      repeat (4) @(negedge MCLK_IN);
      chk("run late", 1, RUN_OUT);
   endtask

   // One access: hold request until taken, then watch the pins
   task automatic run_row(input emb_row_t r);
      logic [4:0] seen;
      logic strb;
      logic [15:0] rd;
      seen = 0;
      strb = 0;
      rd = 0;
      n = 0;
      lat = 0;
      @(negedge MCLK_IN);
      {ADV_MODE_IN, WRL_MODE_IN, WRH_MODE_IN, CFG_IN[1], BUS_WIDTH_SELECT_IN, ONCHIP_ROM_SELECT_IN} = r.mode;
      REQ_IN = r.req;
      REQ_VALID_IN = 1;
      while (REQ_READY_OUT !== 1'b1 && n < 40)
      begin
         @(negedge MCLK_IN);
         n++;
      end
      chk("taken", 1, n < 40);
      seen[4] = ONCHIP_SEL_OUT;
      for (int i = 0; i < 40; i++)
      begin
         @(negedge MCLK_IN);
         REQ_VALID_IN = 0;
         seen[3:0] |= {!RD_N_OUT, !LOW_BYTE_STORE_N_OUT, !HIGH_BYTE_STORE_N_OUT, FETCH_INDICATOR_OUT};
         strb |= ADDR_STROBE_OUT ^ r.mode[5];
         if (RDATA_VALID_OUT === 1'b1)
         begin
            rd = RDATA_OUT;
            lat = i;
         end
      end
      chk("pins seen", r.exp, seen);
      chk("addr strobe", !r.exp[4], strb);
      chk("strobe idle", 0, ADDR_STROBE_OUT ^ r.mode[5]);
      if (r.req.rd && !r.exp[4] && r.req.wdata != 0)
      begin
         chk("read data", r.req.wdata, rd);
         if (waits == 0)
            chk("latency", 9, lat);
      end
   endtask

   initial
   begin
      reset_seq();
      foreach (rows[i])
         run_row(rows[i]);
      waits = 3;
      run_row(rows[4]);
      chk("wait stretch", 12, lat);
      waits = 0;
      n = 0;
      for (int i = 0; i < 30; i++)
      begin
         @(negedge MCLK_IN);
         n += DIVIDED_CLOCK_OUTPUT_OUT === 1'b1;
      end
      chk("clock high", 10, n);
      NMI_IN = 1;
      n = 0;
      repeat (6) @(negedge MCLK_IN) n += NMI_VECTOR_OUT === 1'b1;
      chk("nmi pulse", 1, n);
      chk("nmi addr", 16'h0000, NMI_ADDR_OUT);
      reset_seq();
      PROG_LEVEL_IN = 1;
      repeat (4) @(negedge MCLK_IN);
      chk("prog mode", 1, PROG_MODE_OUT);
      summarize();
   end

   // Watchdog well beyond the expected run
   initial
   begin
      #400000;
      errors++;
      summarize();
   end
endmodule
